// ---- phy_misc_map.svh ----
`ifndef PHY_MISC_MAP_SVH
`define PHY_MISC_MAP_SVH

// device register offsets and fields
`define REGULATOR_CONTROL_OFFSET 16'h00d0
`define REGULATOR_OFF_BIT        15
`define REGULATOR_CONTROL_RESET  16'h0000
`define PIN_CONFIG_OFFSET        16'h0011
`define PIN_CONFIG_IRQ_BIT       0
`define PIN_CONFIG_LED_MODE_BIT  1
`define PIN_CONFIG_RESET         16'h0000
`define IRQ_STATUS_OFFSET        16'h0012
`define IRQ_STATUS_RESET         16'h0000

// timing, clock of 10 MHz
`define CLOCK_HZ                 10000000
`define RESET_MIN_NS             1000
`define RESET_MIN_CYCLES         ((`RESET_MIN_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)
`define BLINK_HALF_MS            4
`define BLINK_HALF_CYCLES        (`BLINK_HALF_MS * (`CLOCK_HZ / 1000))

// controller axi-lite map
`define CTL_COMMAND_OFFSET       32'h00
`define CTL_STATUS_OFFSET        32'h04
`define CTL_IRQ_STATUS_OFFSET    32'h08
`define CTL_IRQ_MASK_OFFSET      32'h0c
`define CTL_REG_ADDR_OFFSET      32'h10
`define CTL_REG_DATA_OFFSET      32'h14
`define CTL_COMMAND_RESET        32'h00000000

`endif

// ---- phy_misc_pkg.sv ----
package phy_misc_pkg;
  typedef enum logic { led_mode_link, led_mode_activity } led_mode_t;
  typedef enum logic { pin_as_powerdown, pin_as_interrupt } pin_role_t;
endpackage : phy_misc_pkg

// ---- phy_misc_if.sv ----
`timescale 1ns/1ns
interface phy_misc_if;
  logic        reset_n;        // active-low hardware reset from controller
  logic        pin_host_oe;    // controller pulls shared pin low
  logic        pin_dev_oe;     // device pulls shared pin low
  logic        pin_level;      // resolved level of the shared pin
  logic        reg_we;         // register write strobe
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  // open drain with weak pull-up
  assign pin_level = ~(pin_host_oe | pin_dev_oe);
  modport device (input reset_n, input pin_host_oe, output pin_dev_oe,
                  input pin_level, input reg_we, input reg_addr,
                  input reg_wdata, output reg_rdata);
  modport host (output reset_n, output pin_host_oe, input pin_dev_oe,
                input pin_level, output reg_we, output reg_addr,
                output reg_wdata, input reg_rdata);
endinterface : phy_misc_if

// ---- phy_misc_device.sv ----
`timescale 1ns/1ns
`include "phy_misc_map.svh"
module phy_misc_device #(
  parameter int BLINK_HALF = `BLINK_HALF_CYCLES
) (
  // clock, reset
  input  wire logic clock,
  input  wire logic nrst,
  // link to controller
  phy_misc_if.device link,
  // device core side
  input  wire logic mii_mode_strap,
  input  wire logic led_mode_strap,
  input  wire logic negotiation_duplex_strap,
  input  wire logic link_good,
  input  wire logic tx_active,
  input  wire logic rx_active,
  input  wire logic irq_event,
  output logic      link_indicator_pin,
  output logic      powered_down,
  output logic      regulator_off,
  output logic      rmii_selected,
  output logic      full_duplex
);
  // the blink timer needs at least one cycle per half period
  if (BLINK_HALF < 1) begin : g_blink_check
    $error("blink half period must be positive");
  end

  logic        rst_n;
  logic [15:0] regulator_control, next_regulator_control;
  logic [15:0] pin_config, next_pin_config;
  logic        irq_pend, next_irq_pend;
  logic [2:0]  straps, next_straps;
  logic        strap_done, next_strap_done;
  logic [31:0] blink_cnt, next_blink_cnt;
  logic        blink, next_blink;
  logic        act_seen, next_act_seen;
  phy_misc_pkg::led_mode_t led_mode;
  phy_misc_pkg::pin_role_t pin_role;

  // either reset source clears everything
  assign rst_n = nrst & link.reset_n; // RULE_06

  assign led_mode = phy_misc_pkg::led_mode_t'(
    pin_config[`PIN_CONFIG_LED_MODE_BIT]);
  assign pin_role = phy_misc_pkg::pin_role_t'(
    pin_config[`PIN_CONFIG_IRQ_BIT]);

  // register writes, strap capture after release, sticky interrupt
  always_comb begin
    next_regulator_control = regulator_control;
    next_pin_config        = pin_config;
    next_irq_pend          = irq_pend | irq_event; // set wins
    next_straps            = straps;
    next_strap_done        = 1'b1;
    if (!strap_done) begin
      next_straps = {mii_mode_strap, led_mode_strap,
                     negotiation_duplex_strap}; // RULE_06
      next_pin_config[`PIN_CONFIG_LED_MODE_BIT] = led_mode_strap;
    end
    if (link.reg_we) begin
      unique case (link.reg_addr)
        `REGULATOR_CONTROL_OFFSET:
          next_regulator_control = link.reg_wdata; // RULE_11
        `PIN_CONFIG_OFFSET:
          next_pin_config = link.reg_wdata; // RULE_07
        `IRQ_STATUS_OFFSET:
          if (link.reg_wdata[0] && !irq_event) next_irq_pend = 1'b0;
        default: ;
      endcase
    end
  end

  // registers return to defaults on reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regulator_control <= `REGULATOR_CONTROL_RESET;
      pin_config        <= `PIN_CONFIG_RESET; // RULE_07
      irq_pend          <= 1'b0;
      straps            <= 3'h0;
      strap_done        <= 1'b0;
    end else begin
      regulator_control <= next_regulator_control;
      pin_config        <= next_pin_config;
      irq_pend          <= next_irq_pend;
      straps            <= next_straps;
      strap_done        <= next_strap_done;
    end
  end

  // blink timer, stretches short bursts to a visible pulse
  always_comb begin
    next_blink_cnt = blink_cnt;
    next_blink     = blink;
    next_act_seen  = act_seen | tx_active | rx_active;
    if (blink_cnt >= 32'(BLINK_HALF - 1)) begin
      next_blink_cnt = 32'h0; // RULE_12
      next_blink     = act_seen ? ~blink : 1'b0;
      next_act_seen  = tx_active | rx_active;
    end else begin
      next_blink_cnt = blink_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= 32'h0;
      blink     <= 1'b0;
      act_seen  <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink     <= next_blink;
      act_seen  <= next_act_seen;
    end
  end

  // outputs
  always_comb begin
    unique case (led_mode)
      phy_misc_pkg::led_mode_link:
        link_indicator_pin = link_good; // RULE_03
      phy_misc_pkg::led_mode_activity:
        link_indicator_pin = link_good & ~blink; // RULE_04
    endcase
  end
  assign regulator_off = regulator_control[`REGULATOR_OFF_BIT]; // RULE_11
  assign powered_down  = (pin_role == phy_misc_pkg::pin_as_powerdown)
                         & link.pin_host_oe; // RULE_08
  assign link.pin_dev_oe = (pin_role == phy_misc_pkg::pin_as_interrupt)
                           & irq_pend; // RULE_09
  assign rmii_selected = straps[2];
  assign full_duplex   = straps[0];
  always_comb begin
    unique case (link.reg_addr)
      `REGULATOR_CONTROL_OFFSET: link.reg_rdata = regulator_control;
      `PIN_CONFIG_OFFSET:        link.reg_rdata = pin_config;
      `IRQ_STATUS_OFFSET:        link.reg_rdata = {15'h0, irq_pend};
      default:                   link.reg_rdata = 16'h0;
    endcase
  end
endmodule : phy_misc_device

// ---- phy_misc_host.sv ----
`timescale 1ns/1ns
`include "phy_misc_map.svh"
// Summary of operation
// [RULE_01] MII mode needs 25 MHz reference clock
// [RULE_02] RMII mode needs 50 MHz reference clock
// [RULE_03] LED mode 1: LED shows link
// [RULE_04] LED mode 2: link on, blink on activity
// [RULE_05] reset low at least 1 us
// [RULE_06] reset restores registers and resamples straps
// [RULE_07] shared pin is powerdown until reconfigured
// [RULE_08] low shared pin enters power down
// [RULE_09] interrupt role pulls pin low open-drain
// [RULE_10] software powers down regulator at 0x00d0
// [RULE_11] bit 15 one powers down regulator
// [RULE_12] activity blink has fixed millisecond period
module phy_misc_host #(
  parameter int RESET_CYCLES = `RESET_MIN_CYCLES
) (
  // clock, reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // link to device
  phy_misc_if.host         link,
  // axi4-lite slave
  input  wire logic [31:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [31:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // interrupt
  output logic             irq
);
  // the pulse counter is eight bits wide and must count at least once
  if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_reset_check
    $error("reset pulse length out of range");
  end

  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] command, next_command;
  logic [15:0] reg_addr, next_reg_addr, reg_data, next_reg_data;
  logic [1:0]  ist, next_ist, imask, next_imask;
  logic [7:0]  rst_cnt, next_rst_cnt;
  logic        we_pulse, next_we_pulse;
  logic        pin_prev, next_pin_prev;
  logic        do_write, reset_busy;
  logic [1:0]  events;

  assign s_awready  = ~aw_held & ~s_bvalid;
  assign s_wready   = ~w_held & ~s_bvalid;
  assign s_arready  = ~s_rvalid;
  assign do_write   = aw_held & w_held & ~s_bvalid;
  assign reset_busy = rst_cnt != 8'h0;
  // event 0: reset pulse done, event 1: shared pin fell, whichever side pulls it
  assign events = {pin_prev & ~link.pin_level,
                   reset_busy & (rst_cnt == 8'h1)};

  always_comb begin
    next_aw_held  = aw_held | (s_awvalid & s_awready);
    next_w_held   = w_held | (s_wvalid & s_wready);
    next_aw_addr  = (s_awvalid & s_awready) ? s_awaddr : aw_addr;
    next_w_data   = (s_wvalid & s_wready) ? s_wdata : w_data;
    next_bvalid   = s_bvalid & ~s_bready;
    next_bresp    = s_bresp;
    next_rvalid   = s_rvalid & ~s_rready;
    next_rresp    = s_rresp;
    next_rdata    = s_rdata;
    next_command  = command;
    next_reg_addr = reg_addr;
    next_reg_data = reg_data;
    next_imask    = imask;
    next_ist      = ist | events; // set wins over clear
    next_rst_cnt  = reset_busy ? rst_cnt - 8'h1 : 8'h0;
    next_we_pulse = 1'b0;
    next_pin_prev = link.pin_level;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = 2'b00;
      unique case (aw_addr[7:0])
        8'h00: begin
          next_command = w_data;
          if (w_data[0]) next_rst_cnt = 8'(RESET_CYCLES); // RULE_05
          if (w_data[2]) next_we_pulse = 1'b1; // RULE_10
        end
        8'h08: next_ist = (ist & ~w_data[1:0]) | events;
        8'h0c: next_imask = w_data[1:0];
        8'h10: next_reg_addr = w_data[15:0];
        8'h14: next_reg_data = w_data[15:0];
        default: next_bresp = 2'b10;
      endcase
    end
    if (s_arvalid & s_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      unique case (s_araddr[7:0])
        8'h00: next_rdata = command;
        8'h04: next_rdata = {29'h0, link.pin_level, reset_busy, 1'b0};
        8'h08: next_rdata = {30'h0, ist};
        8'h0c: next_rdata = {30'h0, imask};
        8'h10: next_rdata = {16'h0, reg_addr};
        8'h14: next_rdata = {16'h0, link.reg_rdata};
        default: begin
          next_rdata = 32'h0;
          next_rresp = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 32'h0;
      w_data   <= 32'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= 2'b00;
      s_rvalid <= 1'b0;
      s_rresp  <= 2'b00;
      s_rdata  <= 32'h0;
      command  <= `CTL_COMMAND_RESET;
      reg_addr <= 16'h0;
      reg_data <= 16'h0;
      ist      <= 2'h0;
      imask    <= 2'h0;
      rst_cnt  <= 8'h0;
      we_pulse <= 1'b0;
      pin_prev <= 1'b1;
    end else begin
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      s_bvalid <= next_bvalid;
      s_bresp  <= next_bresp;
      s_rvalid <= next_rvalid;
      s_rresp  <= next_rresp;
      s_rdata  <= next_rdata;
      command  <= next_command;
      reg_addr <= next_reg_addr;
      reg_data <= next_reg_data;
      ist      <= next_ist;
      imask    <= next_imask;
      rst_cnt  <= next_rst_cnt;
      we_pulse <= next_we_pulse;
      pin_prev <= next_pin_prev;
    end
  end

  // reset held low for the whole counted pulse
  assign link.reset_n     = ~reset_busy; // RULE_05
  assign link.pin_host_oe = command[1]; // RULE_08
  assign link.reg_we      = we_pulse;
  assign link.reg_addr    = reg_addr;
  assign link.reg_wdata   = reg_data;
  assign irq              = |(ist & imask);
endmodule : phy_misc_host

// ---- phy_misc_properties.sv ----
`timescale 1ns/1ns
`include "phy_misc_map.svh"
module phy_misc_check #(
  parameter int RESET_CYCLES = `RESET_MIN_CYCLES
) (
  // clock, reset
  input wire logic        clock,
  input wire logic        nrst,
  // interface signals
  input wire logic        reset_n,
  input wire logic        pin_dev_oe,
  input wire logic        reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  logic [7:0] low_cnt;
  logic       role;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // shadow of reset length and pin role; role must drop with reset_n
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 8'h00;
      role <= 1'b0;
    end else begin
      low_cnt <= reset_n ? 8'h00 : low_cnt + 8'h01;
      if (!reset_n)
        role <= 1'b0;
      else if (reg_we && reg_addr == `PIN_CONFIG_OFFSET)
        role <= reg_wdata[`PIN_CONFIG_IRQ_BIT];
    end
  end
  property p_reset_len;
    $rose(reset_n) |-> low_cnt >= RESET_CYCLES;
  endproperty
  property p_quiet;
    !reset_n |-> !pin_dev_oe;
  endproperty
  property p_reg_rst;
    $rose(reset_n) && reg_addr == `REGULATOR_CONTROL_OFFSET
      |-> reg_rdata == `REGULATOR_CONTROL_RESET;
  endproperty
  property p_reg_wr;
    reg_we && reg_addr == `REGULATOR_CONTROL_OFFSET
      ##1 reg_addr == $past(reg_addr)
      |-> reg_rdata[`REGULATOR_OFF_BIT]
          == $past(reg_wdata[`REGULATOR_OFF_BIT]);
  endproperty
  property p_cfg_wr;
    reg_we && reg_addr == `PIN_CONFIG_OFFSET
      ##1 reg_addr == $past(reg_addr)
      |-> reg_rdata[1:0] == $past(reg_wdata[1:0]);
  endproperty
  property p_role;
    pin_dev_oe |-> role || $past(role);
  endproperty
  property p_irq_pin;
    pin_dev_oe && $past(pin_dev_oe) && reg_addr == `IRQ_STATUS_OFFSET
      && !reg_we
      && !$past(reg_we) |-> reg_rdata[0];
  endproperty
  property p_we_pulse;
    reg_we |=> !reg_we;
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("short reset");
  a_quiet: assert property (p_quiet)
    else $error("pin in reset");
  a_reg_rst: assert property (p_reg_rst)
    else $error("reg not reset");
  a_reg_wr: assert property (p_reg_wr)
    else $error("regulator bit");
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("config bits");
  a_role: assert property (p_role)
    else $error("pin role");
  a_irq_pin: assert property (p_irq_pin)
    else $error("pin no irq");
  a_we_pulse: assert property (p_we_pulse)
    else $error("long strobe");
  c_reset: cover property ($rose(reset_n));
  c_irq: cover property (pin_dev_oe);
  c_reg: cover property (reg_we && reg_addr == `REGULATOR_CONTROL_OFFSET);
endmodule : phy_misc_check

// ---- test_phy_clock_led_reset_powerdown.sv ----
`timescale 1ns/1ns
module test_phy_clock_led_reset_powerdown;
  logic clock, nrst, mii_mode_strap, led_mode_strap, negotiation_duplex_strap;
  logic link_good, tx_active, rx_active, irq_event, link_indicator_pin;
  logic powered_down, regulator_off, rmii_selected, full_duplex, irq;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, d;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [3:0]  s_wstrb;
  int          errors = 0, checks = 0, cyc = 0, n;
  int          dev_model[int];
  phy_misc_if link_if();
  phy_misc_device #(.BLINK_HALF(4)) phy_misc_device_i (.clock, .nrst,
    .link(link_if.device), .mii_mode_strap, .led_mode_strap,
    .negotiation_duplex_strap, .link_good, .tx_active, .rx_active,
    .irq_event, .link_indicator_pin, .powered_down, .regulator_off,
    .rmii_selected, .full_duplex);
  phy_misc_host #(.RESET_CYCLES(10)) phy_misc_host_i (.clock, .nrst,
    .link(link_if.host), .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .irq);
  phy_misc_check #(.RESET_CYCLES(10)) phy_misc_check_i (.clock, .nrst,
    .reset_n(link_if.reset_n), .pin_dev_oe(link_if.pin_dev_oe),
    .reg_we(link_if.reg_we), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_rdata(link_if.reg_rdata));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick
  // both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    r = s_bresp;
    s_bready <= 1'b0;
    // let an edge pass so the next call never re-drives in this step
    @(posedge clock);
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge clock);
  endtask : axi_rd
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    axi_rd(a);
    chk(d, e);
  endtask : rd_chk
  // device write goes address, data, then the issue command
  task automatic dev_wr(input logic [31:0] a, input logic [31:0] v);
    dev_model[a] = v;
    axi_wr(32'h10, a);
    axi_wr(32'h14, v);
    axi_wr(32'h00, 32'h4);
    tick(3);
  endtask : dev_wr
  task automatic led_cnt(input int e);
    int k;
    k = 0;
    repeat (32) begin
      @(posedge clock);
      k += link_indicator_pin;
    end
    chk(k, e);
  endtask : led_cnt
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    {nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_wdata, s_araddr} = '0;
    {link_good, tx_active, rx_active, irq_event, led_mode_strap} = '0;
    s_wstrb = 4'hf;
    void'($urandom(76148));
    {mii_mode_strap, negotiation_duplex_strap} = 2'($urandom);
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    tick(2);
    chk(rmii_selected, mii_mode_strap);
    chk(full_duplex, negotiation_duplex_strap);
    chk({powered_down, regulator_off}, 0);
    rd_chk(32'h08, 0);
    rd_chk(32'h40, 0);
    chk(r, 2'h2);
    axi_wr(32'h40, 32'h0);
    chk(r, 2'h2);
    $display("done defaults");
    repeat (8) begin
      link_good <= 1'($urandom);
      tick(1);
      chk(link_indicator_pin, link_good);
    end
    $display("done link led");
    dev_wr(32'hd0, 32'h8000);
    chk(regulator_off, 1);
    rd_chk(32'h14, dev_model[32'hd0]);
    $display("done regulator");
    axi_wr(32'h00, 32'h2);
    tick(3);
    chk(powered_down, 1);
    rd_chk(32'h08, 32'h2);
    chk(irq, 0);
    axi_wr(32'h0c, 32'h2);
    tick(1);
    chk(irq, 1);
    axi_wr(32'h08, 32'h2);
    tick(1);
    chk(irq, 0);
    axi_wr(32'h00, 32'h0);
    tick(2);
    chk(powered_down, 0);
    $display("done powerdown irq");
    mii_mode_strap <= ~mii_mode_strap;
    axi_wr(32'h00, 32'h1);
    axi_rd(32'h04);
    chk(d & 32'h2, 32'h2);
    n = 0;
    d = 0;
    while (d[0] !== 1'b1 && n < 50) begin
      axi_rd(32'h08);
      n++;
    end
    chk(d & 32'h1, 32'h1);
    tick(2);
    dev_model.delete();
    chk(regulator_off, 0);
    chk(rmii_selected, mii_mode_strap);
    chk(!rmii_selected, !mii_mode_strap);
    rd_chk(32'h14, 0);
    $display("done hw reset");
    dev_wr(32'h11, 32'h3);
    irq_event <= 1'b1;
    tick(1);
    irq_event <= 1'b0;
    tick(3);
    chk(powered_down, 0);
    axi_rd(32'h04);
    chk(d & 32'h4, 0);
    dev_wr(32'h12, 32'h1);
    axi_rd(32'h04);
    chk(d & 32'h4, 32'h4);
    $display("done irq role");
    link_good <= 1'b1;
    tx_active <= 1'b1;
    tick(4);
    led_cnt(16);
    tx_active <= 1'b0;
    rx_active <= 1'b1;
    led_cnt(16);
    rx_active <= 1'b0;
    tick(16);
    led_cnt(32);
    link_good <= 1'b0;
    tick(2);
    led_cnt(0);
    $display("done activity led");
    end_of_test();
  end
endmodule : test_phy_clock_led_reset_powerdown
